/* logic/ppei_pkg.sv */
// package: register map, field positions and reset values of the pin edge interrupt block
// Operation
// - edges detected always, irq only when master enabled; here change_irq, wake_req and the istat wake bit use it, irq via the edge bit does not
// - rising edge detected only if rising enable set
// - falling edge detected only if falling enable set
// - both enables set gives both edge directions
// - enabled edge sets pin flag, irq if enabled
// - summary flag reads one when any flag set
// - writing zero clears a pin flag
// - edge during flag write leaves flag set
// - enabled edge in sleep wakes when master enabled
// - flags updated before first instruction after wake
// - rising enable eight rw bits reset zero
// - falling enable eight rw bits reset zero
// - flag register eight bits hardware set, reset zero
package ppei_pkg;
    localparam int PPEI_PINS = 8;
    localparam int PPEI_AW = 5;
    localparam logic [PPEI_AW-1:0] PPEI_OFS_RISE = 5'h00;
    localparam logic [PPEI_AW-1:0] PPEI_OFS_FALL = 5'h04;
    localparam logic [PPEI_AW-1:0] PPEI_OFS_FLAGS = 5'h08;
    localparam logic [PPEI_AW-1:0] PPEI_OFS_CTRL = 5'h0c;
    localparam logic [PPEI_AW-1:0] PPEI_OFS_ISTAT = 5'h10;
    localparam logic [PPEI_AW-1:0] PPEI_OFS_IMASK = 5'h14;
    localparam int PPEI_CTRL_MASTER_BIT = 0;
    localparam int PPEI_CTRL_SUMMARY_BIT = 1;
    localparam int PPEI_CTRL_SLEEP_BIT = 2;
    localparam int PPEI_IST_EDGE_BIT = 0;
    localparam int PPEI_IST_WAKE_BIT = 1;
    localparam int PPEI_IST_W = 2;
    localparam logic [7:0] PPEI_RST_BYTE = 8'h00;
    localparam logic [1:0] PPEI_RESP_OKAY = 2'h0;
    localparam logic [1:0] PPEI_RESP_SLVERR = 2'h2;
endpackage

/* logic/ppei_sync.sv */
// two-flop synchroniser for the port pins
`timescale 1ns/1ps
module ppei_sync
    import ppei_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [PPEI_PINS-1:0] pins_async,
    output logic [PPEI_PINS-1:0] pins_sync
);
    logic [PPEI_PINS-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            pins_sync <= '0;
        end else begin
            meta_q <= pins_async;
            pins_sync <= meta_q;
        end
    end
endmodule

/* logic/ppei_edge.sv */
// per-pin edge detector with rising and falling enables
`timescale 1ns/1ps
module ppei_edge
    import ppei_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [PPEI_PINS-1:0] level,
    input wire logic [PPEI_PINS-1:0] rise_en,
    input wire logic [PPEI_PINS-1:0] fall_en,
    output logic [PPEI_PINS-1:0] edge_hit
);
    logic [PPEI_PINS-1:0] prev_q;
    logic primed_q;
    wire [PPEI_PINS-1:0] rising = level & ~prev_q;
    wire [PPEI_PINS-1:0] falling = ~level & prev_q;

    // primed keeps the first sample after reset from looking like an edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= '0;
            primed_q <= 1'b0;
        end else begin
            prev_q <= level;
            primed_q <= 1'b1;
        end
    end

    assign edge_hit = primed_q ? ((rising & rise_en) | (falling & fall_en)) : '0;
endmodule

/* logic/ppei_top.sv */
// pin edge interrupt block with axi4-lite register slave
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module ppei_top
    import ppei_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [PPEI_PINS-1:0] port_pin_n,
    input wire logic sleep_active,
    input wire logic [PPEI_AW-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [PPEI_AW-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic change_irq,
    output logic wake_req,
    output logic irq
);
    logic [PPEI_PINS-1:0] pins_s;
    logic [PPEI_PINS-1:0] hit;
    logic [7:0] rising_edge_enable_q;
    logic [7:0] falling_edge_enable_q;
    logic [7:0] pin_change_flags_q;
    logic [7:0] pin_change_flags_d;
    logic change_irq_master_enable_q;
    logic [PPEI_IST_W-1:0] istat_q;
    logic [PPEI_IST_W-1:0] istat_d;
    logic [PPEI_IST_W-1:0] imask_q;
    logic sleep_s1_q;
    logic sleep_q;
    logic aw_have_q;
    logic w_have_q;
    logic [PPEI_AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    ppei_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins_async(port_pin_n),
        .pins_sync(pins_s)
    );

    ppei_edge u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(pins_s),
        .rise_en(rising_edge_enable_q),
        .fall_en(falling_edge_enable_q),
        .edge_hit(hit)
    );

    // write channel: address and data taken in either order, one write at a time
    wire aw_take = s_awvalid && s_awready;
    wire w_take = s_wvalid && s_wready;
    wire aw_ok = aw_have_q || aw_take;
    wire w_ok = w_have_q || w_take;
    wire wr_fire = aw_ok && w_ok && !s_bvalid;
    wire [PPEI_AW-1:0] wa = aw_have_q ? awaddr_q : s_awaddr;
    wire [31:0] wd = w_have_q ? wdata_q : s_wdata;
    wire [3:0] ws = w_have_q ? wstrb_q : s_wstrb;
    wire wb0 = wr_fire && ws[0];
    wire wr_rise = wb0 && (wa == PPEI_OFS_RISE);
    wire wr_fall = wb0 && (wa == PPEI_OFS_FALL);
    wire wr_flags = wb0 && (wa == PPEI_OFS_FLAGS);
    wire wr_ctrl = wb0 && (wa == PPEI_OFS_CTRL);
    wire wr_istat = wb0 && (wa == PPEI_OFS_ISTAT);
    wire wr_imask = wb0 && (wa == PPEI_OFS_IMASK);
    wire wa_known = (wa == PPEI_OFS_RISE) || (wa == PPEI_OFS_FALL) || (wa == PPEI_OFS_FLAGS) ||
                    (wa == PPEI_OFS_CTRL) || (wa == PPEI_OFS_ISTAT) || (wa == PPEI_OFS_IMASK);

    // hardware set wins over a software clear in the same cycle
    assign pin_change_flags_d = (wr_flags ? wd[7:0] : pin_change_flags_q) | hit;

    // summary flag is any flag, independent of the master enable
    wire summary = |pin_change_flags_q;
    wire any_hit = |hit;
    wire wake_evt = any_hit && sleep_q && change_irq_master_enable_q;
    wire [PPEI_IST_W-1:0] ist_evt = {wake_evt, any_hit};
    assign istat_d = (istat_q & ~(wr_istat ? wd[PPEI_IST_W-1:0] : '0)) | ist_evt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rising_edge_enable_q <= PPEI_RST_BYTE;
            falling_edge_enable_q <= PPEI_RST_BYTE;
            pin_change_flags_q <= PPEI_RST_BYTE;
            change_irq_master_enable_q <= 1'b0;
            imask_q <= '0;
            istat_q <= '0;
        end else begin
            if (wr_rise) begin
                rising_edge_enable_q <= wd[7:0];
            end
            if (wr_fall) begin
                falling_edge_enable_q <= wd[7:0];
            end
            if (wr_ctrl) begin
                change_irq_master_enable_q <= wd[PPEI_CTRL_MASTER_BIT];
            end
            if (wr_imask) begin
                imask_q <= wd[PPEI_IST_W-1:0];
            end
            pin_change_flags_q <= pin_change_flags_d;
            istat_q <= istat_d;
        end
    end

    // sleep comes from the core's power logic, which may run apart from aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_s1_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            sleep_s1_q <= sleep_active;
            sleep_q <= sleep_s1_q;
        end
    end

    // outputs registered from next-state values; irq and wake change in the same cycle as the flags,
    // so the flags are already set when the core sees the wake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            change_irq <= 1'b0;
            wake_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            change_irq <= change_irq_master_enable_q && (|pin_change_flags_d);
            wake_req <= change_irq_master_enable_q && sleep_q && (|pin_change_flags_d);
            irq <= |(istat_d & imask_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= PPEI_RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_q <= s_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wa_known ? PPEI_RESP_OKAY : PPEI_RESP_SLVERR;
            end else begin
                aw_have_q <= aw_ok;
                w_have_q <= w_ok;
                if (s_bvalid && s_bready) begin
                    s_bvalid <= 1'b0;
                end
            end
            s_awready <= !aw_ok && !wr_fire && !s_bvalid && !s_awready;
            s_wready <= !w_ok && !wr_fire && !s_bvalid && !s_wready;
        end
    end

    // read channel
    wire ar_take = s_arvalid && s_arready;
    wire [7:0] ctrl_rd = {5'h00, sleep_q, summary, change_irq_master_enable_q};
    wire [31:0] rd_mux = (s_araddr == PPEI_OFS_RISE) ? {24'h000000, rising_edge_enable_q} :
                         (s_araddr == PPEI_OFS_FALL) ? {24'h000000, falling_edge_enable_q} :
                         (s_araddr == PPEI_OFS_FLAGS) ? {24'h000000, pin_change_flags_q} :
                         (s_araddr == PPEI_OFS_CTRL) ? {24'h000000, ctrl_rd} :
                         (s_araddr == PPEI_OFS_ISTAT) ? {30'h00000000, istat_q} :
                         (s_araddr == PPEI_OFS_IMASK) ? {30'h00000000, imask_q} : 32'h00000000;
    wire ra_known = (s_araddr == PPEI_OFS_RISE) || (s_araddr == PPEI_OFS_FALL) ||
                    (s_araddr == PPEI_OFS_FLAGS) || (s_araddr == PPEI_OFS_CTRL) ||
                    (s_araddr == PPEI_OFS_ISTAT) || (s_araddr == PPEI_OFS_IMASK);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= PPEI_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_rvalid <= 1'b1;
                s_rdata <= rd_mux;
                s_rresp <= ra_known ? PPEI_RESP_OKAY : PPEI_RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
            s_arready <= s_arvalid && !s_arready && !s_rvalid && !ar_take;
        end
    end
endmodule

/* tb/ppei_assertions.sv */
// checker: handshake and interrupt relations at the pin edge block ports
`timescale 1ns/1ps
module ppei_assertions
    import ppei_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [PPEI_PINS-1:0] port_pin_n,
    input wire logic s_awready,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic change_irq,
    input wire logic wake_req,
    input wire logic irq
);
    logic [7:0] prev_q;
    logic [3:0] quiet_q;
    // cycles since the pins last moved, saturating so it never wraps back to a recent value
    always_ff @(posedge aclk) begin
        prev_q <= port_pin_n;
        if (!aresetn || port_pin_n != prev_q) quiet_q <= 4'h0;
        else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence b_wait;
        s_bvalid && !s_bready;
    endsequence
    sequence ar_taken;
        s_arvalid && s_arready;
    endsequence
    sequence cause_seen;
        $past(s_bvalid) || quiet_q < 4'h8;
    endsequence
    bvalid_hold_a: assert property (b_wait |=> s_bvalid) else $error("bvalid dropped early");
    rdata_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata)) else $error("rdata moved");
    read_answer_a: assert property (ar_taken |=> s_rvalid) else $error("no read answer");
    rdata_byte_a: assert property (s_rvalid |-> s_rdata[31:8] == 24'h0) else $error("upper read bits set");
    bresp_code_a: assert property (s_bvalid |-> s_bresp == PPEI_RESP_OKAY || s_bresp == PPEI_RESP_SLVERR)
        else $error("bad bresp");
    aw_pulse_a: assert property (s_awready |=> !s_awready) else $error("awready not a pulse");
    wake_master_a: assert property (wake_req |-> change_irq) else $error("wake without change irq");
    change_cause_a: assert property ($rose(change_irq) |-> cause_seen) else $error("change irq uncaused");
    irq_cause_a: assert property ($rose(irq) |-> cause_seen) else $error("irq uncaused");
endmodule
bind ppei_top ppei_assertions u_ppei_assertions (.*);

/* tb/ppei_pin_drv.sv */
// partner: external driver of the port pins
`timescale 1ns/1ps
module ppei_pin_drv (
    input wire logic aclk,
    input wire logic [7:0] level_cmd,
    output logic [7:0] port_pin_n
);
    initial port_pin_n = 8'h00;
    // pins move on the falling edge, away from the synchroniser's sampling edge
    always @(negedge aclk) port_pin_n <= level_cmd;
endmodule

/* tb/tb.sv */
// testbench: register, edge, interrupt and sleep scenarios for the pin edge block
`timescale 1ns/1ps
module tb;
    import ppei_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, sleep_active = 1'b0;
    logic [7:0] pin_cmd = 8'h00;
    logic [4:0] s_awaddr = 5'h00, s_araddr = 5'h00;
    logic [31:0] s_wdata = 32'h0, rd;
    logic [3:0] s_wstrb = 4'h0;
    logic [1:0] rsp;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    wire logic [7:0] port_pin_n;
    wire logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, change_irq, wake_req, irq;
    wire logic [1:0] s_bresp, s_rresp;
    wire logic [31:0] s_rdata;
    int n_fail = 0, check_count = 0, cyc = 0;
    always #2.5 aclk = ~aclk;
    ppei_pin_drv u_ppei_pin_drv (.aclk(aclk), .level_cmd(pin_cmd), .port_pin_n(port_pin_n));
    ppei_top u_ppei_top (.*);
    task automatic give_verdict;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // the run needs a few hundred cycles, so this only trips on a hang
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    // readies are sampled mid-cycle, then acted on at the edge that takes them
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic ta, tw, tv;
        @(posedge aclk);
        {s_awaddr, s_wdata, s_wstrb} <= {a, 24'h0, d, 4'h1};
        {s_awvalid, s_wvalid, s_bready} <= 3'h7;
        do begin
            @(negedge aclk);
            {ta, tw, tv, rsp} = {s_awready, s_wready, s_bvalid, s_bresp};
            @(posedge aclk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
        end while (!tv);
        s_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [4:0] a);
        logic ta, tv;
        @(posedge aclk);
        {s_araddr, s_arvalid, s_rready} <= {a, 2'h3};
        do begin
            @(negedge aclk);
            {ta, tv, rd, rsp} = {s_arready, s_rvalid, s_rdata, s_rresp};
            @(posedge aclk);
            if (ta) s_arvalid <= 1'b0;
        end while (!tv);
        s_rready <= 1'b0;
    endtask
    task automatic flip(input logic [7:0] m);
        @(posedge aclk);
        pin_cmd <= pin_cmd ^ m;
        repeat (8) @(negedge aclk);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 4; i++) begin
            rdr(5'(i * 4));
            chk("reset value", 32'h0, rd);
        end
        rdr(5'h18);
        chk("unmapped resp", 32'(PPEI_RESP_SLVERR), 32'(rsp));
        wr(5'h18, 8'h55);
        chk("unmapped bresp", 32'(PPEI_RESP_SLVERR), 32'(rsp));
        wr(PPEI_OFS_IMASK, 8'h00);
        chk("mapped bresp", 32'(PPEI_RESP_OKAY), 32'(rsp));
    endtask
    task automatic t_modes;
        logic [7:0] r, f;
        for (int k = 0; k < 3; k++) begin
            r = (k != 1) ? 8'h0f : 8'h00;
            f = (k != 0) ? 8'h0f : 8'h00;
            wr(PPEI_OFS_RISE, r);
            wr(PPEI_OFS_FALL, f);
            rdr(PPEI_OFS_FALL);
            chk("fall enable", {24'h0, f}, rd);
            flip(8'h33);
            rdr(PPEI_OFS_FLAGS);
            chk("flags rising", {24'h0, r & 8'h03}, rd);
            wr(PPEI_OFS_FLAGS, 8'h00);
            flip(8'h33);
            rdr(PPEI_OFS_FLAGS);
            chk("flags falling", {24'h0, f & 8'h03}, rd);
            chk("change irq off", 32'h0, {31'h0, change_irq});
            wr(PPEI_OFS_FLAGS, 8'h00);
            rdr(PPEI_OFS_FLAGS);
            chk("flags cleared", 32'h0, rd);
        end
    endtask
    task automatic t_irq;
        wr(PPEI_OFS_CTRL, 8'h01);
        wr(PPEI_OFS_RISE, 8'hff);
        rdr(PPEI_OFS_RISE);
        chk("rise enable", 32'hff, rd);
        flip(8'h80);
        chk("change irq", 32'h1, {31'h0, change_irq});
        rdr(PPEI_OFS_CTRL);
        chk("summary flag", 32'h3, rd);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(PPEI_OFS_IMASK, 8'h01);
        repeat (2) @(negedge aclk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(PPEI_OFS_ISTAT, 8'h03);
        repeat (2) @(negedge aclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rdr(PPEI_OFS_FLAGS);
        chk("flag pin7", 32'h80, rd);
        wr(PPEI_OFS_FLAGS, rd[7:0] & (rd[7:0] ^ 8'hff));
        repeat (2) @(negedge aclk);
        chk("change irq cleared", 32'h0, {31'h0, change_irq});
    endtask
    task automatic t_sleep;
        wr(PPEI_OFS_FALL, 8'hff);
        sleep_active <= 1'b1;
        flip(8'h80);
        chk("wake", 32'h1, {31'h0, wake_req});
        rdr(PPEI_OFS_FLAGS);
        chk("flags at wake", 32'h80, rd);
        rdr(PPEI_OFS_CTRL);
        chk("ctrl in sleep", 32'h7, rd);
        sleep_active <= 1'b0;
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_modes();
        t_irq();
        t_sleep();
        give_verdict();
    end
endmodule
